// ---- design/cell_port_pkg.sv ----
// Purpose: shared constants of the cell port, both ends
// Assumes: byte wide cells, four channels, one reference clock per end
// Notes: link timing counts derive from the reference clock period
package cell_port_pkg;
    localparam int CELL_LEN = 53;
    localparam int HDR_LEN = 4;
    localparam int PAY_OFS = 5;
    localparam int PAY_LEN = CELL_LEN - PAY_OFS;
    localparam int IN_SLACK = 4;
    localparam int FIFO_SLACK = 2;
    localparam int SYNC_LEN = 3;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int HDR_W = 32;
    localparam int MIN_CLK_RATIO = 3;
    localparam int REF_PERIOD_NS = 8;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_HALF = LINK_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int IN_DEPTH_DEF = 256;
    localparam int OUT_DEPTH_DEF = 256;
    localparam int TAG_LEN_DEF = 0;
endpackage

// ---- design/cell_port_if.sv ----
// Purpose: pins between the cell master and the cell port device
// Assumes: the master makes both link clocks
// Notes: shared pins change meaning with the interface mode bit;
//   cell_in_space_avail doubles as cell_in_fifo_full_n,
//   cell_in_enable_n as cell_in_write_strobe_n,
//   cell_out_cell_ready as cell_out_fifo_empty_n,
//   cell_out_enable_n as the read strobe
interface cell_port_if;
    logic cell_in_clock;
    logic cell_out_clock;
    logic [7:0] cell_in_bus;
    logic cell_in_first_byte;
    logic cell_in_enable_n;
    logic cell_in_space_avail;
    logic [7:0] cell_out_bus_o;
    logic cell_out_first_byte_o;
    logic cell_out_oe;
    logic cell_out_cell_ready;
    logic cell_out_enable_n;
    logic cell_out_drive_enable;
    // released pins show the inverse of the last value
    wire [7:0] cell_out_bus = cell_out_oe ? cell_out_bus_o : ~cell_out_bus_o;
    wire cell_out_first_byte =
        cell_out_oe ? cell_out_first_byte_o : ~cell_out_first_byte_o;

    modport device (
        input cell_in_clock, cell_out_clock, cell_in_bus,
        input cell_in_first_byte, cell_in_enable_n,
        input cell_out_enable_n, cell_out_drive_enable,
        output cell_in_space_avail, cell_out_bus_o,
        output cell_out_first_byte_o, cell_out_oe, cell_out_cell_ready
    );
    modport host (
        output cell_in_clock, cell_out_clock, cell_in_bus,
        output cell_in_first_byte, cell_in_enable_n,
        output cell_out_enable_n, cell_out_drive_enable,
        input cell_in_space_avail, cell_out_bus, cell_out_first_byte,
        input cell_out_cell_ready
    );
endinterface

// ---- design/two_entry_buffer.sv ----
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, pop and push in one cycle allowed
// Notes: full stalls the source, so no word is lost on a stall
module two_entry_buffer
    import cell_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] slot_q [2];
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    if (WIDTH < 1) begin : g_bad_width
        $error("two_entry_buffer: WIDTH must be at least 1");
    end

    assign in_ready = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;
    assign out_data = slot_q[0];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            slot_q[0] <= '0;
            slot_q[1] <= '0;
            cnt_q <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    slot_q[cnt_q[0]] <= in_data;
                    cnt_q <= cnt_q + 2'h1;
                end
                2'b01: begin
                    slot_q[0] <= slot_q[1];
                    cnt_q <= cnt_q - 2'h1;
                end
                2'b11: begin
                    if (cnt_q == 2'h1) begin
                        slot_q[0] <= in_data;
                    end else begin
                        slot_q[0] <= slot_q[1];
                        slot_q[1] <= in_data;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// ---- design/cell_port_device.sv ----
// Purpose: cell input and output port of a four-channel AAL1 device
// Assumes: both link clocks come from the master and are sampled here
// Notes: link pins pass three flops; a level counts when stages agree
// Function
// - master input clock above three line clocks
// - input byte sampled at input clock fall
// - start flag marks first byte, sampled fall
// - space flag per whole cell, four-byte slack; code asks two payloads free
// - fifo full flag low, two-byte slack
// - utopia mode: enable qualifies input bytes
// - fifo mode: same pin is write strobe
// - master output clock above three line clocks
// - output bytes and tag valid at rise
// - start flag on first byte or tag
// - cell ready high with complete cell
// - fifo mode: ready pin is empty_n
// - utopia: enable high floats output pins
// - fifo: read strobe never floats pins
// - fifo mode: drive enable floats pins while header check is off
// - matching cells taken, unmatched headers dropped even with header check off
// - reset clears fifos and handshake outputs except tx_ready, which reset sets high
module cell_port_device
    import cell_port_pkg::*;
#(
    parameter int IN_DEPTH = IN_DEPTH_DEF,
    parameter int OUT_DEPTH = OUT_DEPTH_DEF,
    parameter int TAG_LEN = TAG_LEN_DEF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    cell_port_if.device link,
    input wire logic utopia_mode,
    input wire logic header_check_enable,
    input wire logic [HDR_W-1:0] channel_header [NUM_CH],
    input wire logic [NUM_CH-1:0] channel_enable,
    output logic [7:0] rx_data,
    output logic [CH_W-1:0] rx_channel,
    output logic rx_first,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    localparam int IAW = $clog2(IN_DEPTH);
    localparam int OAW = $clog2(OUT_DEPTH);
    localparam int UNIT = CELL_LEN + TAG_LEN;

    if (IN_DEPTH != (1 << IAW) || IN_DEPTH < 2 * PAY_LEN + IN_SLACK ||
        OUT_DEPTH != (1 << OAW) || OUT_DEPTH < UNIT ||
        TAG_LEN < 0 || UNIT > 127) begin : g_bad_param
        $error("cell_port_device: unsupported depth or tag length");
    end

    logic [10:0] is_q [SYNC_LEN];
    logic [2:0] os_q [SYNC_LEN];
    logic in_lvl_q;
    logic out_lvl_q;
    logic in_fall;
    logic out_rise;
    logic out_fall;
    logic [7:0] in_bus;
    logic in_soc;
    logic in_take;

    // stage 0 feeds only stage 1; edges look at stages 1 and 2
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < SYNC_LEN; i++) begin
                is_q[i] <= '0;
                os_q[i] <= '0;
            end
        end else begin
            is_q[0] <= {link.cell_in_clock, link.cell_in_first_byte,
                        link.cell_in_enable_n, link.cell_in_bus};
            os_q[0] <= {link.cell_out_clock, link.cell_out_enable_n,
                        link.cell_out_drive_enable};
            for (int i = 1; i < SYNC_LEN; i++) begin
                is_q[i] <= is_q[i-1];
                os_q[i] <= os_q[i-1];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_lvl_q <= 1'b0;
            out_lvl_q <= 1'b0;
        end else begin
            if (is_q[1][10] == is_q[2][10]) begin
                in_lvl_q <= is_q[2][10];
            end
            if (os_q[1][2] == os_q[2][2]) begin
                out_lvl_q <= os_q[2][2];
            end
        end
    end

    assign in_fall = (is_q[1][10] == is_q[2][10]) & in_lvl_q & ~is_q[2][10];
    assign out_rise = (os_q[1][2] == os_q[2][2]) & ~out_lvl_q & os_q[2][2];
    assign out_fall = (os_q[1][2] == os_q[2][2]) & out_lvl_q & ~os_q[2][2];
    assign in_bus = is_q[2][7:0];
    assign in_soc = is_q[2][9];
    assign in_take = in_fall & ~is_q[2][8];

    logic [23:0] hdr_q;
    logic hit;
    logic [CH_W-1:0] hit_ch;

    always_comb begin
        hit = 1'b0;
        hit_ch = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (channel_enable[i] && channel_header[i] == {hdr_q, in_bus}) begin
                hit = 1'b1;
                hit_ch = CH_W'(i);
            end
        end
    end

    logic [9:0] imem [IN_DEPTH];
    logic [IAW:0] iwr_q;
    logic [IAW:0] icm_q;
    logic [IAW:0] ird_q;
    logic [5:0] ibyte_q;
    logic in_cell_q;
    logic keep_q;
    logic drop_q;
    logic [CH_W-1:0] ich_q;
    logic [IAW:0] ifree;
    logic ipay;
    logic iwrite;

    assign ifree = (IAW+1)'(IN_DEPTH) - (iwr_q - ird_q);
    assign ipay = in_take & ~in_soc & in_cell_q & (ibyte_q >= 6'(PAY_OFS));
    assign iwrite = ipay & keep_q & ~drop_q & (ifree != '0);

    always_ff @(posedge ref_clk) begin
        if (iwrite) begin
            imem[iwr_q[IAW-1:0]] <= {ich_q, in_bus};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            iwr_q <= '0;
            icm_q <= '0;
            ibyte_q <= 6'h00;
            in_cell_q <= 1'b0;
            keep_q <= 1'b0;
            drop_q <= 1'b0;
            ich_q <= '0;
            hdr_q <= 24'h000000;
        end else if (in_take && in_soc) begin
            iwr_q <= icm_q;
            ibyte_q <= 6'h01;
            in_cell_q <= 1'b1;
            keep_q <= 1'b0;
            drop_q <= 1'b0;
            hdr_q <= {16'h0000, in_bus};
        end else if (in_take && in_cell_q) begin
            ibyte_q <= ibyte_q + 6'h01;
            if (ibyte_q < 6'(HDR_LEN - 1)) begin
                hdr_q <= {hdr_q[15:0], in_bus};
            end
            if (ibyte_q == 6'(HDR_LEN - 1)) begin
                keep_q <= hit;
                ich_q <= hit_ch;
            end
            if (iwrite) begin
                iwr_q <= iwr_q + 1'b1;
            end else if (ipay && keep_q) begin
                // overflow spoils the whole cell
                drop_q <= 1'b1;
            end
            if (ibyte_q == 6'(CELL_LEN - 1)) begin
                in_cell_q <= 1'b0;
                if (iwrite) begin
                    icm_q <= iwr_q + 1'b1;
                end else begin
                    iwr_q <= icm_q;
                end
            end
        end
    end

    logic space_q;

    // conservative: a cell in flight may still need a full payload
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            space_q <= 1'b0;
        end else if (in_fall) begin
            if (utopia_mode) begin
                // room for two whole payloads
                space_q <= ifree >= (IAW+1)'(2 * PAY_LEN);
            end else begin
                space_q <= ifree > (IAW+1)'(FIFO_SLACK);
            end
        end
    end

    logic [5:0] rcnt_q;
    logic ipend;
    logic rb_ready;

    assign ipend = ird_q != icm_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ird_q <= '0;
            rcnt_q <= 6'h00;
        end else if (ipend && rb_ready) begin
            ird_q <= ird_q + 1'b1;
            rcnt_q <= (rcnt_q == 6'(PAY_LEN - 1)) ? 6'h00 : rcnt_q + 6'h01;
        end
    end

    two_entry_buffer #(.WIDTH(11)) rx_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data({rcnt_q == 6'h00, imem[ird_q[IAW-1:0]]}),
        .in_valid(ipend),
        .in_ready(rb_ready),
        .out_data({rx_first, rx_channel, rx_data}),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    logic [7:0] tb_data;
    logic tb_valid;
    logic tb_ready;
    logic [7:0] omem [OUT_DEPTH];
    logic [OAW:0] owr_q;
    logic [OAW:0] ord_q;
    logic [6:0] wcnt_q;
    logic opush;
    logic ocommit;

    two_entry_buffer #(.WIDTH(8)) tx_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(tb_data),
        .out_valid(tb_valid),
        .out_ready(tb_ready)
    );

    assign tb_ready = (owr_q - ord_q) != (OAW+1)'(OUT_DEPTH);
    assign opush = tb_valid & tb_ready;
    assign ocommit = opush & (wcnt_q == 7'(UNIT - 1));

    always_ff @(posedge ref_clk) begin
        if (opush) begin
            omem[owr_q[OAW-1:0]] <= tb_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            owr_q <= '0;
            wcnt_q <= 7'h00;
        end else if (opush) begin
            owr_q <= owr_q + 1'b1;
            wcnt_q <= ocommit ? 7'h00 : wcnt_q + 7'h01;
        end
    end

    logic [OAW:0] units_q;
    logic [OAW:0] units_d;
    logic busy_q;
    logic [6:0] ocnt_q;
    logic en_seen_q;
    logic ostep;
    logic ostart;
    logic olast;
    logic [7:0] bus_q;
    logic soc_q;
    logic oe_q;
    logic ready_q;

    assign ostep = out_rise & en_seen_q & (busy_q | (units_q != '0));
    assign ostart = ostep & ~busy_q;
    assign olast = ocnt_q == 7'(UNIT - 1);
    assign units_d = units_q + (OAW+1)'(ocommit) - (OAW+1)'(ostart);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            units_q <= '0;
        end else begin
            units_q <= units_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ord_q <= '0;
            busy_q <= 1'b0;
            ocnt_q <= 7'h00;
            bus_q <= 8'h00;
            soc_q <= 1'b0;
        end else if (ostep) begin
            bus_q <= omem[ord_q[OAW-1:0]];
            soc_q <= ocnt_q == 7'h00;
            ord_q <= ord_q + 1'b1;
            ocnt_q <= olast ? 7'h00 : ocnt_q + 7'h01;
            busy_q <= ~olast;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ready_q <= 1'b0;
        end else if (out_rise) begin
            ready_q <= units_d != '0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en_seen_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (out_fall) begin
            en_seen_q <= ~os_q[2][1];
            if (utopia_mode) begin
                oe_q <= ~os_q[2][1];
            end else begin
                oe_q <= ~(os_q[2][0] & ~header_check_enable);
            end
        end
    end

    assign link.cell_in_space_avail = space_q;
    assign link.cell_out_bus_o = bus_q;
    assign link.cell_out_first_byte_o = soc_q;
    assign link.cell_out_oe = oe_q;
    assign link.cell_out_cell_ready = ready_q;
endmodule

// ---- design/cell_port_host.sv ----
// Purpose: cell master end: makes link clocks, sends and reads cells
// Assumes: user hands whole cells, first byte flagged
// Notes: reads only whole units after seeing the ready pin
module cell_port_host
    import cell_port_pkg::*;
#(
    parameter int TAG_LEN = TAG_LEN_DEF,
    parameter int HALF = LINK_HALF
) (
    input wire logic ref_clk,
    input wire logic nrst,
    cell_port_if.host link,
    input wire logic utopia_mode,
    input wire logic [7:0] tx_data,
    input wire logic tx_first,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_valid
);
    localparam int UNIT = CELL_LEN + TAG_LEN;

    if (HALF < 2 * SYNC_LEN + 2 || HALF > 255 || UNIT > 127) begin : g_bad
        $error("cell_port_host: link half period or tag too short/long");
    end

    logic [7:0] hcnt_q;
    logic ci_q;
    logic co_q;
    logic rise;

    assign rise = (hcnt_q == 8'(HALF - 1)) & ~ci_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hcnt_q <= 8'h00;
            ci_q <= 1'b0;
            co_q <= 1'b0;
        end else if (hcnt_q == 8'(HALF - 1)) begin
            hcnt_q <= 8'h00;
            ci_q <= ~ci_q;
            co_q <= ~co_q;
        end else begin
            hcnt_q <= hcnt_q + 8'h01;
        end
    end

    logic [10:0] hs_q [SYNC_LEN];
    logic [10:0] flt_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < SYNC_LEN; i++) begin
                hs_q[i] <= '0;
            end
            flt_q <= '0;
        end else begin
            hs_q[0] <= {link.cell_in_space_avail, link.cell_out_cell_ready,
                        link.cell_out_first_byte, link.cell_out_bus};
            for (int i = 1; i < SYNC_LEN; i++) begin
                hs_q[i] <= hs_q[i-1];
            end
            // a bit changes only when stages 1 and 2 agree
            flt_q <= (hs_q[1] & hs_q[2]) | (flt_q & (hs_q[1] | hs_q[2]));
        end
    end

    logic [7:0] hb_data;
    logic hb_first;
    logic hb_valid;
    logic hb_pop;
    logic send;
    logic [5:0] tcnt_q;
    logic [7:0] bus_q;
    logic soc_q;
    logic wen_n_q;

    two_entry_buffer #(.WIDTH(9)) tx_buf (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data({tx_first, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data({hb_first, hb_data}),
        .out_valid(hb_valid),
        .out_ready(hb_pop)
    );

    always_comb begin
        send = 1'b0;
        if (rise && hb_valid && (tcnt_q != 6'h00 || hb_first)) begin
            send = utopia_mode ? (tcnt_q != 6'h00 || flt_q[10]) : flt_q[10];
        end
    end
    // stray bytes outside a cell are discarded to regain alignment
    assign hb_pop = send | (rise & hb_valid & tcnt_q == 6'h00 & ~hb_first);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tcnt_q <= 6'h00;
            bus_q <= 8'h00;
            soc_q <= 1'b0;
            wen_n_q <= 1'b1;
        end else if (rise) begin
            wen_n_q <= ~send;
            if (send) begin
                bus_q <= hb_data;
                soc_q <= hb_first;
                if (hb_first) begin
                    tcnt_q <= 6'h01;
                end else if (tcnt_q == 6'(CELL_LEN - 1)) begin
                    tcnt_q <= 6'h00;
                end else begin
                    tcnt_q <= tcnt_q + 6'h01;
                end
            end
        end
    end

    logic [6:0] rrem_q;
    logic ren_n_q;
    logic [1:0] sh_q;
    logic ren_n_d;
    logic [7:0] rx_data_q;
    logic rx_first_q;
    logic rx_valid_q;

    assign ren_n_d = (rrem_q == 7'h00) ? ~flt_q[9] : 1'b0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rrem_q <= 7'h00;
            ren_n_q <= 1'b1;
            sh_q <= 2'b00;
        end else if (rise) begin
            ren_n_q <= ren_n_d;
            sh_q <= {sh_q[0], ~ren_n_d};
            if (rrem_q != 7'h00) begin
                rrem_q <= rrem_q - 7'h01;
            end else if (flt_q[9]) begin
                rrem_q <= 7'(UNIT - 1);
            end
        end
    end

    // take at fall; floats by next rise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_data_q <= 8'h00;
            rx_first_q <= 1'b0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= (hcnt_q == 8'(HALF - 1)) & ci_q & sh_q[1];
            if (hcnt_q == 8'(HALF - 1) && ci_q && sh_q[1]) begin
                rx_data_q <= flt_q[7:0];
                rx_first_q <= flt_q[8];
            end
        end
    end

    assign rx_data = rx_data_q;
    assign rx_first = rx_first_q;
    assign rx_valid = rx_valid_q;
    assign link.cell_in_clock = ci_q;
    assign link.cell_out_clock = co_q;
    assign link.cell_in_bus = bus_q;
    assign link.cell_in_first_byte = soc_q;
    assign link.cell_in_enable_n = wen_n_q;
    assign link.cell_out_enable_n = ren_n_q;
    assign link.cell_out_drive_enable = 1'b0;
endmodule

// ---- tb/cell_port_properties.sv ----
// Purpose: link pin checks between both cell port ends
// Assumes: host half period of 10 reference cycles
// Notes: device edges lag its pin synchroniser
module cell_port_properties (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic utopia_mode,
    input wire logic cell_in_clock,
    input wire logic cell_out_clock,
    input wire logic [7:0] cell_in_bus,
    input wire logic cell_in_first_byte,
    input wire logic cell_in_enable_n,
    input wire logic cell_in_space_avail,
    input wire logic [7:0] cell_out_bus_o,
    input wire logic cell_out_first_byte_o,
    input wire logic cell_out_oe,
    input wire logic cell_out_cell_ready,
    input wire logic cell_out_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] off_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // saturates: only a long idle span matters
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            off_q <= 5'h0;
        else if (!cell_out_enable_n)
            off_q <= 5'h0;
        else if (off_q != 5'h1f)
            off_q <= off_q + 5'h1;
    end
    chk_in_clock_half: assert property (
        $rose(cell_in_clock) |=> cell_in_clock [*8] ##1 cell_in_clock
            ##1 !cell_in_clock) else $error("input clock half period");
    chk_clocks_phase: assert property (
        cell_out_clock == cell_in_clock) else $error("clocks out of phase");
    chk_in_pins_step: assert property (
        $changed({cell_in_bus, cell_in_first_byte, cell_in_enable_n})
            |-> $rose(cell_in_clock)) else $error("input pins off rise");
    chk_space_at_fall: assert property (
        $changed(cell_in_space_avail) |-> !cell_in_clock)
        else $error("space flag off fall");
    chk_ready_at_rise: assert property (
        $changed(cell_out_cell_ready) |-> cell_out_clock)
        else $error("ready flag off rise");
    chk_out_bus_step: assert property (
        $changed(cell_out_bus_o) |-> cell_out_clock && cell_out_oe)
        else $error("output byte off rise");
    chk_first_stands: assert property (
        $rose(cell_out_first_byte_o) |-> (cell_out_clock && cell_out_oe)
            ##1 cell_out_first_byte_o [*8]) else $error("first flag short");
    chk_idle_floats: assert property (
        utopia_mode && off_q >= 5'h14 |-> !cell_out_oe)
        else $error("output driven while idle");
    cover property ($fell(cell_in_enable_n) && cell_in_first_byte);
    cover property ($rose(cell_out_first_byte_o) && !utopia_mode);
    cover property ($fell(cell_in_space_avail));
endmodule

// ---- tb/aal1_cell_port_test.sv ----
// Purpose: bench joining both cell port ends
// Assumes: whole cells only; channel 3 left disabled
// Notes: each mode stalls the receiver to fill the input
`define chk(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module aal1_cell_port_test
    import cell_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, nrst = 1'h0, utopia_mode = 1'h1, go = 1'h0;
    logic header_check_enable = 1'h0, dev_rx_ready = 1'h0;
    logic [HDR_W-1:0] channel_header [NUM_CH];
    logic [NUM_CH-1:0] channel_enable = 4'h7;
    logic [7:0] host_tx_data = 8'h0, dev_tx_data = 8'h0, e;
    logic host_tx_first = 1'h0, host_tx_valid = 1'h0, dev_tx_valid = 1'h0;
    logic host_tx_ready, host_rx_first, host_rx_valid, dev_tx_ready;
    logic [7:0] host_rx_data, dev_rx_data, dev_q [$], host_q [$];
    logic [CH_W-1:0] dev_rx_channel, chan_q [$];
    logic dev_rx_first, dev_rx_valid, fdev_q [$], fhost_q [$];
    int err_total = 0, samples_checked = 0;
    cell_port_if link ();
    cell_port_host #(.HALF(10)) cell_port_host_i (
        .ref_clk, .nrst, .link(link), .utopia_mode,
        .tx_data(host_tx_data), .tx_first(host_tx_first),
        .tx_valid(host_tx_valid), .tx_ready(host_tx_ready),
        .rx_data(host_rx_data), .rx_first(host_rx_first),
        .rx_valid(host_rx_valid));
    cell_port_device #(.IN_DEPTH(128), .OUT_DEPTH(64)) cell_port_device_i (
        .ref_clk, .nrst, .link(link), .utopia_mode, .header_check_enable,
        .channel_header, .channel_enable, .rx_data(dev_rx_data),
        .rx_channel(dev_rx_channel), .rx_first(dev_rx_first),
        .rx_valid(dev_rx_valid), .rx_ready(dev_rx_ready),
        .tx_data(dev_tx_data), .tx_valid(dev_tx_valid), .tx_ready(dev_tx_ready));
    cell_port_properties cell_port_properties_i (
        .ref_clk, .nrst, .utopia_mode, .cell_in_clock(link.cell_in_clock),
        .cell_out_clock(link.cell_out_clock), .cell_in_bus(link.cell_in_bus),
        .cell_in_first_byte(link.cell_in_first_byte),
        .cell_in_enable_n(link.cell_in_enable_n),
        .cell_in_space_avail(link.cell_in_space_avail),
        .cell_out_bus_o(link.cell_out_bus_o), .cell_out_oe(link.cell_out_oe),
        .cell_out_first_byte_o(link.cell_out_first_byte_o),
        .cell_out_cell_ready(link.cell_out_cell_ready),
        .cell_out_enable_n(link.cell_out_enable_n));
    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) dev_rx_ready <= go & ~dev_rx_ready;
    always @(posedge ref_clk) begin
        if (dev_rx_valid === 1'h1 && dev_rx_ready === 1'h1) begin
            dev_q.push_back(dev_rx_data);
            chan_q.push_back(dev_rx_channel);
            fdev_q.push_back(dev_rx_first);
        end
        if (host_rx_valid === 1'h1) begin
            host_q.push_back(host_rx_data);
            fhost_q.push_back(host_rx_first);
        end
    end
    task automatic host_cell(input logic [31:0] hdr, input logic [7:0] s);
        for (int i = 0; i < CELL_LEN; i++) begin
            @(negedge ref_clk);
            host_tx_data = i < HDR_LEN ? hdr[31 - 8 * i -: 8] : s + 8'(i);
            host_tx_first = (i == 0);
            host_tx_valid = 1'h1;
            while (host_tx_ready !== 1'h1) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        host_tx_valid = 1'h0;
    endtask
    task automatic dev_cells(input logic [7:0] s, input int n);
        for (int k = 0; k < n * CELL_LEN; k++) begin
            @(negedge ref_clk);
            dev_tx_data = s + 8'(k);
            dev_tx_valid = 1'h1;
            while (dev_tx_ready !== 1'h1) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        dev_tx_valid = 1'h0;
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
    initial begin
        for (int c = 0; c < NUM_CH; c++) channel_header[c] = 32'h1234560 + c;
        for (int m = 1; m >= 0; m--) begin
            @(negedge ref_clk);
            nrst = 1'h0;
            utopia_mode = 1'(m);
            go <= 1'h0;
            @(negedge ref_clk);
            `chk("space", 1'h0, link.cell_in_space_avail)
            `chk("oe", 1'h0, link.cell_out_oe)
            `chk("tx ready", 1'h1, dev_tx_ready)
            @(negedge ref_clk);
            nrst = 1'h1;
            dev_q.delete();
            chan_q.delete();
            fdev_q.delete();
            host_q.delete();
            fhost_q.delete();
            fork
                begin
                    host_cell(channel_header[3], 8'hf0);
                    for (int c = 0; c < 3; c++)
                        host_cell(channel_header[c], 8'(8'h30 * c));
                end
                dev_cells(8'h80, 2);
                begin
                    repeat (3000) @(negedge ref_clk);
                    go <= 1'h1;
                end
            join
            for (int i = 0; i < 20000; i++)
                if (dev_q.size() < 144 || host_q.size() < 106)
                    @(negedge ref_clk);
            `chk("rx count", 144, dev_q.size())
            for (int i = 0; i < 3 * PAY_LEN; i++) begin
                e = 8'(8'h30 * (i / PAY_LEN) + PAY_OFS + i % PAY_LEN);
                `chk("payload", e, dev_q[i])
                `chk("channel", CH_W'(i / PAY_LEN), chan_q[i])
                `chk("rx first", i % PAY_LEN == 0, fdev_q[i])
            end
            for (int i = 0; i < 2 * CELL_LEN; i++) begin
                `chk("out byte", 8'(8'h80 + i), host_q[i])
                `chk("out first", i % CELL_LEN == 0, fhost_q[i])
            end
        end
        final_report();
    end
endmodule
